// file: design/bols_pkg.sv
// package for the byte-order lane steering datapath
// assumes a 32-bit big-endian-numbered data path to cache and register file
package bols_pkg;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned LANES = 4;
    localparam int unsigned STR_MAX = 128;
    localparam int unsigned STR_LEN_W = 8;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [6:0] LEN_ZERO = 7'h00;
    localparam logic [STR_LEN_W-1:0] LEN_ONE = 8'h01;
    localparam logic [STR_LEN_W-1:0] LEN_HALF = 8'h02;
    localparam logic [STR_LEN_W-1:0] LEN_WORD = 8'h04;
    localparam logic ENDIAN_BIG = 1'b0;
    localparam logic ENDIAN_LITTLE = 1'b1;

    typedef enum logic [2:0] {
        BOLS_SZ_BYTE,
        BOLS_SZ_HALF,
        BOLS_SZ_WORD,
        BOLS_SZ_STRING,
        BOLS_SZ_MULTI,
        BOLS_SZ_FETCH
    } bols_size_t;

    // one access as the load/store or fetch path presents it
    typedef struct packed {
        logic valid;
        logic store;
        bols_size_t size;
        logic endian;
        logic [31:0] addr;
        logic [31:0] data;
    } bols_req_t;

    // steered result towards register file, decoder or cache
    typedef struct packed {
        logic valid;
        logic store;
        bols_size_t size;
        logic [31:0] addr;
        logic [STR_LEN_W-1:0] len;
        logic [31:0] data;
    } bols_rsp_t;
endpackage

// file: design/bols_steer.sv
// byte-order lane steering between memory side and register/decoder side
// assumes requests are synchronous to clk_sys_i; one result one cycle later
//
// Overview of operation
// - bit 0 is the msb; lsb is bit 7, 15 or 31 by size
// - a set bit b weighs two to the power lsb minus b
// - memory bytes take consecutive addresses from zero
// - every access is big-endian unless marked little-endian
// - bits inside bytes never move; only whole bytes reorder
// - sizes are byte, halfword, word and strings of 1 to 128 bytes
// - load/store multiple moves a sequence of four-byte words
// - operand address is the lowest-numbered byte address
// - big-endian puts the most significant byte at the lowest address
// - little-endian puts the least significant byte at the lowest address
// - little-endian reorders bytes and never alters the address
// - placement and alignment are the same under both byte orders
// - byte order is chosen per access from a region attribute
// - attribute zero means big-endian, one means little-endian
// - little-endian: bytes kept, halfwords and words byte-reversed
// - little-endian fetch words are reversed before cache and decode
// - little-endian raises no extra alignment fault
`timescale 1ns/1ps
module bols_steer #(
    parameter int unsigned STRING_MAX = bols_pkg::STR_MAX
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // access in
    input wire bols_pkg::bols_req_t req_i,
    input wire logic [6:0] str_len_m1_i,
    // steered access out
    output bols_pkg::bols_rsp_t rsp_o,
    output logic misalign_o
);
    bols_pkg::bols_rsp_t rsp_ff, nxt_rsp;
    logic misalign_ff, nxt_misalign;
    logic [31:0] swapped;
    logic little;

    // bits stay in byte order; lane j of the swap is lane 3-j
    genvar g;
    generate
        for (g = 0; g < bols_pkg::LANES; g++) begin : g_lane
            assign swapped[g*bols_pkg::BYTE_W +: bols_pkg::BYTE_W] =
                req_i.data[(bols_pkg::LANES-1-g)*bols_pkg::BYTE_W +: bols_pkg::BYTE_W];
        end
    endgenerate

    always_comb begin
        little = (req_i.endian == bols_pkg::ENDIAN_LITTLE);
        nxt_rsp = rsp_ff;
        nxt_rsp.valid = req_i.valid;
        nxt_rsp.store = req_i.store;
        nxt_rsp.size = req_i.size;
        nxt_rsp.addr = req_i.addr;
        nxt_rsp.len = bols_pkg::LEN_WORD;
        nxt_rsp.data = req_i.data;
        // halfword and byte sit in low bits (lsb 15 or 7); of these two only a little-endian halfword is byte-swapped
        case (req_i.size)
            bols_pkg::BOLS_SZ_BYTE: begin
                nxt_rsp.len = bols_pkg::LEN_ONE;
                nxt_rsp.data = {24'h00_0000, req_i.data[7:0]};
            end
            bols_pkg::BOLS_SZ_HALF: begin
                nxt_rsp.len = bols_pkg::LEN_HALF;
                if (little) begin
                    nxt_rsp.data = {16'h0000, req_i.data[7:0],
                        req_i.data[15:8]};
                end else begin
                    nxt_rsp.data = {16'h0000, req_i.data[15:0]};
                end
            end
            bols_pkg::BOLS_SZ_WORD, bols_pkg::BOLS_SZ_MULTI: begin
                nxt_rsp.data = little ? swapped : req_i.data;
            end
            bols_pkg::BOLS_SZ_FETCH: begin
                nxt_rsp.data = little ? swapped : req_i.data;
            end
            bols_pkg::BOLS_SZ_STRING: begin
                // strings are byte sequences: no reordering in either order
                nxt_rsp.len = {1'b0, str_len_m1_i} + bols_pkg::LEN_ONE;
                nxt_rsp.data = req_i.data;
            end
            default: begin
                nxt_rsp.valid = 1'b0;
            end
        endcase
        // alignment check ignores endian attribute
        nxt_misalign = 1'b0;
        if (req_i.valid) begin
            case (req_i.size)
                bols_pkg::BOLS_SZ_HALF: nxt_misalign = req_i.addr[0];
                bols_pkg::BOLS_SZ_WORD, bols_pkg::BOLS_SZ_MULTI, bols_pkg::BOLS_SZ_FETCH: begin
                    nxt_misalign = |req_i.addr[1:0];
                end
                default: nxt_misalign = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rsp_ff <= '0;
            misalign_ff <= 1'b0;
        end else begin
            rsp_ff <= nxt_rsp;
            misalign_ff <= nxt_misalign;
        end
    end

    assign rsp_o = rsp_ff;
    assign misalign_o = misalign_ff;

    sequence s_le_word;
        req_i.valid && req_i.endian && (req_i.size == bols_pkg::BOLS_SZ_WORD);
    endsequence

    sequence s_le_half;
        req_i.valid && req_i.endian && (req_i.size == bols_pkg::BOLS_SZ_HALF);
    endsequence

    sequence s_be_half;
        req_i.valid && !req_i.endian && (req_i.size == bols_pkg::BOLS_SZ_HALF);
    endsequence

    sequence s_le_fetch;
        req_i.valid && req_i.endian && (req_i.size == bols_pkg::BOLS_SZ_FETCH);
    endsequence

    sequence s_be_fetch;
        req_i.valid && !req_i.endian && (req_i.size == bols_pkg::BOLS_SZ_FETCH);
    endsequence

    sequence s_be_multi;
        req_i.valid && !req_i.endian && (req_i.size == bols_pkg::BOLS_SZ_MULTI);
    endsequence

    sequence s_string;
        req_i.valid && (req_i.size == bols_pkg::BOLS_SZ_STRING);
    endsequence

    a_word_le_swap: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_le_word |=> rsp_o.data == {$past(req_i.data[7:0]), $past(req_i.data[15:8]),
            $past(req_i.data[23:16]), $past(req_i.data[31:24])})
        else $error("little-endian word not reversed");
    a_word_be_pass: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.valid && !req_i.endian && req_i.size == bols_pkg::BOLS_SZ_WORD
        |=> rsp_o.data == $past(req_i.data))
        else $error("big-endian word altered");
    a_half_le_swap: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_le_half |=> rsp_o.data == {16'h0000, $past(req_i.data[7:0]), $past(req_i.data[15:8])})
        else $error("little-endian halfword not reversed");
    a_byte_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.valid && req_i.size == bols_pkg::BOLS_SZ_BYTE
        |=> rsp_o.data == {24'h00_0000, $past(req_i.data[7:0])})
        else $error("byte operand reordered");
    a_fetch_le: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_le_fetch |=> rsp_o.data == {$past(req_i.data[7:0]), $past(req_i.data[15:8]),
            $past(req_i.data[23:16]), $past(req_i.data[31:24])})
        else $error("fetch word not in decoder order");
    a_addr_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.valid |=> rsp_o.valid && rsp_o.addr == $past(req_i.addr))
        else $error("address changed by steering");
    a_align_same: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.valid && req_i.size == bols_pkg::BOLS_SZ_WORD
        |=> misalign_o == ($past(req_i.addr[1:0]) != 2'b00))
        else $error("alignment depends on byte order");
    a_string_len: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_string |=> rsp_o.len >= bols_pkg::LEN_ONE && rsp_o.len <= STRING_MAX
            && rsp_o.len == {1'b0, $past(str_len_m1_i)} + bols_pkg::LEN_ONE)
        else $error("string length out of range");
    a_multi_le: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.valid && req_i.endian && req_i.size == bols_pkg::BOLS_SZ_MULTI
        |=> rsp_o.len == bols_pkg::LEN_WORD && rsp_o.data == {$past(req_i.data[7:0]),
            $past(req_i.data[15:8]), $past(req_i.data[23:16]), $past(req_i.data[31:24])})
        else $error("multiple word not steered");
    a_half_be_pass: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_be_half |=> rsp_o.data == {16'h0000, $past(req_i.data[15:0])})
        else $error("big-endian halfword altered");
    a_fetch_be_pass: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_be_fetch |=> rsp_o.data == $past(req_i.data))
        else $error("big-endian fetch word altered");
    a_multi_be_pass: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_be_multi |=> rsp_o.len == bols_pkg::LEN_WORD && rsp_o.data == $past(req_i.data))
        else $error("big-endian multiple word altered");
    a_string_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        s_string |=> rsp_o.data == $past(req_i.data))
        else $error("string bytes reordered");
    a_fields_follow: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.valid |=> rsp_o.store == $past(req_i.store) && rsp_o.size == $past(req_i.size))
        else $error("access kind not carried through");
    a_idle_quiet: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        !req_i.valid |=> !rsp_o.valid && !misalign_o)
        else $error("result reported for an idle cycle");
    a_half_align: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.valid && req_i.size == bols_pkg::BOLS_SZ_HALF
        |=> misalign_o == $past(req_i.addr[0]))
        else $error("halfword alignment wrong");
    a_fetch_align: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.valid && (req_i.size == bols_pkg::BOLS_SZ_FETCH
        || req_i.size == bols_pkg::BOLS_SZ_MULTI)
        |=> misalign_o == ($past(req_i.addr[1:0]) != 2'b00))
        else $error("word alignment wrong for fetch or multiple");
    a_byte_align: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.valid && (req_i.size == bols_pkg::BOLS_SZ_BYTE
        || req_i.size == bols_pkg::BOLS_SZ_STRING)
        |=> !misalign_o)
        else $error("byte operand flagged misaligned");
    a_len_byte: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.valid && req_i.size == bols_pkg::BOLS_SZ_BYTE
        |=> rsp_o.len == bols_pkg::LEN_ONE)
        else $error("byte length wrong");
    a_len_half: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.valid && req_i.size == bols_pkg::BOLS_SZ_HALF
        |=> rsp_o.len == bols_pkg::LEN_HALF)
        else $error("halfword length wrong");
    a_len_word: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        req_i.valid && (req_i.size == bols_pkg::BOLS_SZ_WORD
        || req_i.size == bols_pkg::BOLS_SZ_FETCH)
        |=> rsp_o.len == bols_pkg::LEN_WORD)
        else $error("word length wrong");
    a_reset_clear: assert property (@(posedge clk_sys_i)
        reset_i |=> rsp_o == '0 && !misalign_o)
        else $error("outputs not cleared by reset");
endmodule

// file: dv/bols_mem_model.sv
// memory-side model: hands back operand bytes in big-endian lane order
// assumes the byte at address a holds a[7:0] plus 8'h11
`timescale 1ns/1ps
module bols_mem_model (
    // access
    input wire logic [31:0] addr_i,
    input wire bols_pkg::bols_size_t size_i,
    // memory data
    output logic [31:0] data_o
);
    function automatic logic [7:0] mb(input logic [31:0] a);
        return a[7:0] + 8'h11;
    endfunction
    always_comb begin
        case (size_i)
            bols_pkg::BOLS_SZ_BYTE: data_o = {24'h00_0000, mb(addr_i)};
            bols_pkg::BOLS_SZ_HALF: data_o = {16'h0000, mb(addr_i), mb(addr_i + 1)};
            default: data_o = {mb(addr_i), mb(addr_i + 1), mb(addr_i + 2), mb(addr_i + 3)};
        endcase
    end
endmodule

// file: dv/tb_top.sv
// self-checking bench for the byte-order lane steering datapath
// assumes one registered result per request, one cycle after it
`timescale 1ns/1ps
module tb_top;
    logic clk_sys_i, reset_i, v, st, en, m;
    bols_pkg::bols_size_t sz;
    logic [31:0] ad, wd, memd;
    logic [6:0] lm1;
    bols_pkg::bols_req_t req;
    bols_pkg::bols_rsp_t rsp, r;
    int miscompares, compares, cycles;
    assign req = '{valid: v, store: st, size: sz, endian: en, addr: ad, data: st ? wd : memd};
    bols_steer dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .req_i(req), .str_len_m1_i(lm1),
        .rsp_o(rsp), .misalign_o(m));
    bols_mem_model mem (.addr_i(ad), .size_i(sz), .data_o(memd));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic acc(input logic stx, input bols_pkg::bols_size_t szx, input logic enx,
        input logic [31:0] adx, input logic [31:0] wdx);
        v = 1'b1;
        st = stx;
        sz = szx;
        en = enx;
        ad = adx;
        wd = wdx;
        @(posedge clk_sys_i);
        #1;
        r = rsp;
    endtask
    task automatic results;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic t_loads;
        bols_pkg::bols_size_t szs[5] = '{bols_pkg::BOLS_SZ_BYTE, bols_pkg::BOLS_SZ_HALF,
            bols_pkg::BOLS_SZ_WORD, bols_pkg::BOLS_SZ_MULTI, bols_pkg::BOLS_SZ_FETCH};
        logic [31:0] be[5] = '{32'h0000_0021, 32'h0000_2122, 32'h2122_2324, 32'h2122_2324,
            32'h2122_2324};
        logic [31:0] le[5] = '{32'h0000_0021, 32'h0000_2221, 32'h2423_2221, 32'h2423_2221,
            32'h2423_2221};
        logic [7:0] lens[5] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h04};
        for (int e = 0; e < 2; e++) begin
            for (int i = 0; i < 5; i++) begin
                acc(1'b0, szs[i], e[0], 32'h0000_0010, 32'h0000_0000);
                chk(r.data, e[0] ? le[i] : be[i]);
                chk({24'h00_0000, r.len}, {24'h00_0000, lens[i]});
                chk({30'h0000_0000, r.valid, r.store}, 32'h0000_0002);
                chk({29'h0000_0000, r.size}, {29'h0000_0000, szs[i]});
                chk(r.addr, 32'h0000_0010);
                chk({31'h0000_0000, m}, 32'h0000_0000);
            end
        end
    endtask
    task automatic t_stores;
        acc(1'b1, bols_pkg::BOLS_SZ_WORD, 1'b1, 32'h0000_0020, 32'h1122_3344);
        chk(r.data, 32'h4433_2211);
        chk({30'h0000_0000, r.valid, r.store}, 32'h0000_0003);
        acc(1'b1, bols_pkg::BOLS_SZ_WORD, 1'b1, 32'h0000_0020, r.data);
        chk(r.data, 32'h1122_3344);
        acc(1'b1, bols_pkg::BOLS_SZ_HALF, 1'b1, 32'h0000_001C, 32'h0000_5152);
        chk(r.data, 32'h0000_5251);
        lm1 = 7'h7F;
        acc(1'b1, bols_pkg::BOLS_SZ_STRING, 1'b1, 32'h0000_0014, 32'h8001_C0A5);
        chk(r.data, 32'h8001_C0A5);
        chk({24'h00_0000, r.len}, 32'h0000_0080);
        lm1 = 7'h00;
        acc(1'b0, bols_pkg::BOLS_SZ_STRING, 1'b0, 32'h0000_0014, 32'h0000_0000);
        chk({24'h00_0000, r.len}, 32'h0000_0001);
    endtask
    task automatic t_align;
        for (int e = 0; e < 2; e++) begin
            acc(1'b0, bols_pkg::BOLS_SZ_HALF, e[0], 32'h0000_0011, 32'h0000_0000);
            chk({31'h0000_0000, m}, 32'h0000_0001);
            acc(1'b0, bols_pkg::BOLS_SZ_WORD, e[0], 32'h0000_0012, 32'h0000_0000);
            chk({31'h0000_0000, m}, 32'h0000_0001);
            chk(r.addr, 32'h0000_0012);
            acc(1'b0, bols_pkg::BOLS_SZ_BYTE, e[0], 32'h0000_0013, 32'h0000_0000);
            chk({31'h0000_0000, m}, 32'h0000_0000);
            acc(1'b0, bols_pkg::BOLS_SZ_FETCH, e[0], 32'h0000_0012, 32'h0000_0000);
            chk({31'h0000_0000, m}, 32'h0000_0001);
            acc(1'b0, bols_pkg::BOLS_SZ_MULTI, e[0], 32'h0000_0011, 32'h0000_0000);
            chk({31'h0000_0000, m}, 32'h0000_0001);
            acc(1'b0, bols_pkg::BOLS_SZ_STRING, e[0], 32'h0000_0013, 32'h0000_0000);
            chk({31'h0000_0000, m}, 32'h0000_0000);
        end
    endtask
    task automatic t_reset;
        acc(1'b0, bols_pkg::BOLS_SZ_WORD, 1'b1, 32'h0000_0012, 32'h0000_0000);
        reset_i = 1'b1;
        @(posedge clk_sys_i);
        #1;
        chk({rsp.valid, 7'h00, rsp.len, 15'h0000, m}, 32'h0000_0000);
        chk(rsp.data, 32'h0000_0000);
        reset_i = 1'b0;
        acc(1'b0, bols_pkg::BOLS_SZ_HALF, 1'b1, 32'h0000_001C, 32'h0000_0000);
        chk(r.data, 32'h0000_2E2D);
        chk({31'h0000_0000, m}, 32'h0000_0000);
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            results();
        end
    end
    initial begin
        reset_i = 1'b1;
        v = 1'b0;
        st = 1'b0;
        en = 1'b0;
        ad = 32'h0000_0000;
        wd = 32'h0000_0000;
        sz = bols_pkg::BOLS_SZ_BYTE;
        lm1 = 7'h00;
        repeat (6) @(posedge clk_sys_i);
        #1;
        chk({rsp.valid, 7'h00, rsp.len, 15'h0000, m}, 32'h0000_0000);
        chk(rsp.data, 32'h0000_0000);
        reset_i = 1'b0;
        t_loads();
        t_stores();
        t_align();
        t_reset();
        v = 1'b0;
        @(posedge clk_sys_i);
        #1;
        chk({31'h0000_0000, rsp.valid}, 32'h0000_0000);
        chk({31'h0000_0000, m}, 32'h0000_0000);
        @(posedge clk_sys_i);
        #1;
        results();
    end
endmodule
